// File: verilog/dcw_device_config.sv
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - Wait enters deep sleep when deep-sleep select is 1, else ordinary sleep.
// - Deep-sleep watchdog runs only in deep sleep if enabled; clock-select picks oscillator.
// - Watchdog postscale code selects ratio 1:2^(code+5).
// - Deep-sleep brown-out enable keeps detection on in deep sleep; off only there.
// - Brown-out enable arms brown-out reset outside deep sleep; 0 disables it.
// - Output divisor code selects 1,2,4,8,16,32,64,256.
// - USB PLL enabled when bit is 0; input divider 1,2,3,4,5,6,10,12.
// - PLL input select 1 picks fast RC, 0 picks primary oscillator.
// - Multiplier code selects 15,16,17,18,19,20,21,24.
// - System PLL input divider code selects 1,2,3,4,5,6,10,12.
// - USB ID pin owner 1 gives pin to USB module, 0 to port.
// - One-way bits permit only one reconfiguration after reset when 1.
// - I2C select 1 uses primary pins, 0 uses alternate pins; the code selects alternate pins on 1.
// - User identifier readable by software only while code protection is disabled.
// - Lock bits block writes to remap and module-disable registers.
// - Lock bits change only after the unlock sequence completes.
// - Low-power flash read bit enables the low-power read circuit.
// - JTAG port enable bit gates the port; value 1 after power-on; the code loads it from word zero bit 2 once reset is released.
// - TDO enable selects TDO use in two-wire mode; 1 after power-on.
// - Identification register holds 4-bit revision over 28-bit device identifier.
// - Execution is held off for the start-up delay after every power-down.
// - Brown-out with brown-out enable resets and sets reset-control bit 1.
// - Word zero JTAG enable loads the run-time JTAG enable bit.
module dcw_device_config
	import dcw_pkg::*;
#(
	parameter logic [3:0]  REVISION_VALUE = 4'h1,        // Arbitrary value.
	parameter logic [27:0] DEVICE_VALUE   = 28'h0000123, // Arbitrary value.
	parameter int          STARTUP_CYCLES = DCW_STARTUP_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] nvm_word0,
	input  wire logic [31:0] nvm_word2,
	input  wire logic [31:0] nvm_word3,
	input  wire logic        wait_instr,
	input  wire logic        wake_event,
	input  wire logic        brownout_detect,
	input  wire logic        remap_write_req,
	input  wire logic        mdis_write_req,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             deep_sleep_active,
	output logic             sleep_active,
	output logic             cpu_run_enable,
	output logic             ds_watchdog_run,
	output logic             ds_watchdog_clock_select,
	output logic [5:0]       ds_watchdog_ratio_log2,
	output logic             brownout_detect_active,
	output logic             brownout_reset,
	output logic [8:0]       syspll_out_divisor,
	output logic             usbpll_enable,
	output logic [3:0]       usbpll_in_divider,
	output logic             syspll_input_select,
	output logic [4:0]       syspll_multiplier,
	output logic [3:0]       syspll_in_divider,
	output logic             usb_id_pin_owner,
	output logic             i2c_chan1_alt_pins,
	output logic             i2c_chan2_alt_pins,
	output logic             remap_write_grant,
	output logic             mdis_write_grant,
	output logic             low_power_flash_read,
	output logic             jtag_port_enable,
	output logic             two_wire_tdo_enable,
	output logic [15:0]      user_identifier
);

	// ----------------------------------------------------------------
	// Latched configuration words
	// ----------------------------------------------------------------
	logic [31:0] word0_q, word2_q, word3_q;
	logic        loaded_q;

	// The words follow the flash while reset is held and freeze at release.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word0_q  <= nvm_word0;
			word2_q  <= nvm_word2 | DCW_W2_RSVD_MASK;
			word3_q  <= nvm_word3 | DCW_W3_RSVD_MASK;
			loaded_q <= 1'b0;
		end else begin
			loaded_q <= 1'b1;
		end
	end

	wire [4:0] ps_code   = word2_q[DCW_W2_DSWD_PS_LO +: 5];
	wire [2:0] odiv_code = word2_q[DCW_W2_ODIV_LO +: 3];
	wire [2:0] uidv_code = word2_q[DCW_W2_UIDIV_LO +: 3];
	wire [2:0] mul_code  = word2_q[DCW_W2_MUL_LO +: 3];
	wire [2:0] idiv_code = word2_q[DCW_W2_IDIV_LO +: 3];
	wire       code_prot_off = word0_q[DCW_W0_CODE_PROT];

	function automatic logic [3:0] dcw_in_div(input logic [2:0] c);
		unique case (c)
			3'h6:    dcw_in_div = 4'ha;
			3'h7:    dcw_in_div = 4'hc;
			default: dcw_in_div = {1'b0, c} + 4'h1;
		endcase
	endfunction

	wire [8:0] odiv_val = (odiv_code == 3'h7) ? 9'h100 : (9'h001 << odiv_code);
	wire [4:0] mul_val  = (mul_code == 3'h7) ? 5'h18 : (5'h0f + {2'b00, mul_code});

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	dcw_power_t  pstate_q;
	logic [15:0] startup_cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pstate_q      <= DCW_WAKE;
			startup_cnt_q <= 16'h0000;
		end else begin
			unique case (pstate_q)
				DCW_RUN: begin
					if (wait_instr)
						pstate_q <= word2_q[DCW_W2_DS_SELECT] ? DCW_DEEP : DCW_SLEEP;
				end
				DCW_SLEEP, DCW_DEEP: begin
					if (wake_event) begin
						pstate_q      <= DCW_WAKE;
						startup_cnt_q <= 16'h0000;
					end
				end
				DCW_WAKE: begin
					if (startup_cnt_q == 16'(STARTUP_CYCLES - 1))
						pstate_q <= DCW_RUN;
					else
						startup_cnt_q <= startup_cnt_q + 16'h0001;
				end
			endcase
		end
	end

	wire in_deep = (pstate_q == DCW_DEEP);
	wire brown_armed = word2_q[DCW_W2_BROWN_EN] && !in_deep;
	wire det_on = in_deep ? word2_q[DCW_W2_DS_BROWN_EN] : 1'b1;
	wire brown_fire = brownout_detect && brown_armed && loaded_q;

	// ----------------------------------------------------------------
	// Control register and lock logic
	// ----------------------------------------------------------------
	logic       remap_lock_q, mdis_lock_q, flash_lp_q, jtag_en_q, tdo_en_q;
	logic       unlock_stage_q, unlocked_q, brown_flag_q;
	logic       remap_done_q, mdis_done_q;

	// AXI write channel state.
	logic        aw_hold_q, w_hold_q, aw_low_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	// A write above the register window must not alias onto a register.
	wire wr_go   = aw_hold_q && w_hold_q && !s_axi_bvalid;
	wire wr_sel  = wr_go && aw_low_q;
	wire wr_ctl  = wr_sel && (aw_addr_q == DCW_OFF_CONTROL);
	wire wr_unl  = wr_sel && (aw_addr_q == DCW_OFF_UNLOCK);
	wire wr_rst  = wr_sel && (aw_addr_q == DCW_OFF_RESETCTL);
	wire wr_known = wr_ctl || wr_unl || wr_rst;
	wire lane1   = w_strb_q[1];
	wire lane0   = w_strb_q[0];

	wire remap_ok = !remap_lock_q && !(remap_done_q && word3_q[DCW_W3_REMAP_1WAY]);
	wire mdis_ok  = !mdis_lock_q && !(mdis_done_q && word3_q[DCW_W3_MDIS_1WAY]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unlock_stage_q <= 1'b0;
			unlocked_q     <= 1'b0;
		end else if (wr_unl) begin
			unlock_stage_q <= (w_data_q == DCW_KEY_ONE);
			unlocked_q     <= unlock_stage_q && (w_data_q == DCW_KEY_TWO);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remap_lock_q <= 1'b0;
			mdis_lock_q  <= 1'b0;
		end else if (wr_ctl && lane1 && unlocked_q) begin
			remap_lock_q <= w_data_q[DCW_CC_REMAP_LOCK];
			mdis_lock_q  <= w_data_q[DCW_CC_MDIS_LOCK];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_lp_q <= DCW_CC_FLASH_LP_RST;
			jtag_en_q  <= 1'b1;
			tdo_en_q   <= DCW_CC_TDO_EN_RST;
		end else if (!loaded_q) begin
			jtag_en_q  <= word0_q[DCW_W0_JTAG_EN];
		end else begin
			if (wr_ctl && lane1)
				flash_lp_q <= w_data_q[DCW_CC_FLASH_LP];
			if (wr_ctl && lane0) begin
				jtag_en_q <= w_data_q[DCW_CC_JTAG_EN];
				tdo_en_q  <= w_data_q[DCW_CC_TDO_EN];
			end
		end
	end

	// The brown-out flag survives the system reset; a set beats a clear.
	// It holds no defined value until the first brown-out or clear.
	always_ff @(posedge aclk) begin
		if (brown_fire)
			brown_flag_q <= 1'b1;
		else if (wr_rst && lane0 && !w_data_q[DCW_RC_BROWN_FLAG])
			brown_flag_q <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remap_done_q <= 1'b0;
			mdis_done_q  <= 1'b0;
		end else begin
			if (remap_write_req && remap_ok)
				remap_done_q <= 1'b1;
			if (mdis_write_req && mdis_ok)
				mdis_done_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			aw_low_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= DCW_RESP_OKAY;
		end else begin
			// Each ready is the registered form of its channel's next idle state.
			s_axi_awready <= !wr_go && !aw_hold_q && !(s_axi_awvalid && s_axi_awready)
				&& !(s_axi_bvalid && !s_axi_bready);
			s_axi_wready  <= !wr_go && !w_hold_q && !(s_axi_wvalid && s_axi_wready)
				&& !(s_axi_bvalid && !s_axi_bready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_low_q  <= (s_axi_awaddr[31:8] == 24'h000000);
				aw_addr_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? DCW_RESP_OKAY : DCW_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	wire [31:0] ctl_view = DCW_CC_FIXED_ONES
		| ({31'h0, remap_lock_q} << DCW_CC_REMAP_LOCK)
		| ({31'h0, mdis_lock_q} << DCW_CC_MDIS_LOCK)
		| ({31'h0, flash_lp_q} << DCW_CC_FLASH_LP)
		| ({31'h0, jtag_en_q} << DCW_CC_JTAG_EN)
		| ({31'h0, tdo_en_q} << DCW_CC_TDO_EN);
	wire [31:0] w3_view = code_prot_off ? word3_q : {word3_q[31:16], 16'h0000};
	wire [31:0] pwr_view = {30'h0, pstate_q};

	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr[7:0])
			DCW_OFF_CFG0:     rd_mux = word0_q;
			DCW_OFF_CFG2:     rd_mux = word2_q;
			DCW_OFF_CFG3:     rd_mux = w3_view;
			DCW_OFF_CONTROL:  rd_mux = ctl_view;
			DCW_OFF_IDENT:    rd_mux = {REVISION_VALUE, DEVICE_VALUE};
			DCW_OFF_UNLOCK:   rd_mux = {31'h0, unlocked_q};
			DCW_OFF_RESETCTL: rd_mux = {30'h0, brown_flag_q, 1'b0};
			DCW_OFF_POWER:    rd_mux = pwr_view;
			default: begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
		if (s_axi_araddr[31:8] != 24'h0)
			rd_hit = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= DCW_RESP_OKAY;
		end else begin
			s_axi_arready <= !(s_axi_arvalid && s_axi_arready)
				&& !(s_axi_rvalid && !s_axi_rready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_hit ? rd_mux : 32'h00000000;
				s_axi_rresp  <= rd_hit ? DCW_RESP_OKAY : DCW_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deep_sleep_active        <= 1'b0;
			sleep_active             <= 1'b0;
			cpu_run_enable           <= 1'b0;
			ds_watchdog_run          <= 1'b0;
			ds_watchdog_clock_select <= 1'b0;
			ds_watchdog_ratio_log2   <= 6'h00;
			brownout_detect_active   <= 1'b0;
			brownout_reset           <= 1'b0;
			syspll_out_divisor       <= 9'h000;
			usbpll_enable            <= 1'b0;
			usbpll_in_divider        <= 4'h0;
			syspll_input_select      <= 1'b0;
			syspll_multiplier        <= 5'h00;
			syspll_in_divider        <= 4'h0;
			usb_id_pin_owner         <= 1'b0;
			i2c_chan1_alt_pins       <= 1'b0;
			i2c_chan2_alt_pins       <= 1'b0;
			remap_write_grant        <= 1'b0;
			mdis_write_grant         <= 1'b0;
			low_power_flash_read     <= 1'b0;
			jtag_port_enable         <= 1'b0;
			two_wire_tdo_enable      <= 1'b0;
			user_identifier          <= 16'h0000;
		end else begin
			deep_sleep_active        <= in_deep;
			sleep_active             <= (pstate_q == DCW_SLEEP);
			cpu_run_enable           <= (pstate_q == DCW_RUN);
			ds_watchdog_run          <= in_deep && word2_q[DCW_W2_DSWD_EN];
			ds_watchdog_clock_select <= word2_q[DCW_W2_DSWD_CLK];
			ds_watchdog_ratio_log2   <= {1'b0, ps_code} + 6'h05;
			brownout_detect_active   <= det_on;
			brownout_reset           <= brown_fire;
			syspll_out_divisor       <= odiv_val;
			usbpll_enable            <= !word2_q[DCW_W2_UPLL_DIS];
			usbpll_in_divider        <= dcw_in_div(uidv_code);
			syspll_input_select      <= word2_q[DCW_W2_PLL_ICLK];
			syspll_multiplier        <= mul_val;
			syspll_in_divider        <= dcw_in_div(idiv_code);
			usb_id_pin_owner         <= word3_q[DCW_W3_USBID_OWNER];
			i2c_chan1_alt_pins       <= word3_q[DCW_W3_I2C1_ALT];
			i2c_chan2_alt_pins       <= word3_q[DCW_W3_I2C2_ALT];
			remap_write_grant        <= remap_write_req && remap_ok;
			mdis_write_grant         <= mdis_write_req && mdis_ok;
			low_power_flash_read     <= flash_lp_q;
			jtag_port_enable         <= jtag_en_q;
			two_wire_tdo_enable      <= tdo_en_q;
			user_identifier          <= word3_q[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence wait_taken_s;
		pstate_q == DCW_RUN && wait_instr;
	endsequence

	deep_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wait_taken_s ##1 1'b1 |-> (pstate_q == (word2_q[DCW_W2_DS_SELECT] ? DCW_DEEP : DCW_SLEEP)))
		else $error("wait did not select the documented sleep depth");
	dswd_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ds_watchdog_run |-> $past(in_deep))
		else $error("deep-sleep watchdog ran outside deep sleep");
	ratio_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
		loaded_q |=> ds_watchdog_ratio_log2 == 6'($past(ps_code)) + 6'h05)
		else $error("postscale ratio mismatch");
	brown_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		brown_fire |=> brown_flag_q && brownout_reset)
		else $error("brown-out not flagged");
	brown_deep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		in_deep |-> !brown_fire)
		else $error("brown-out reset armed in deep sleep");
	lock_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(remap_lock_q) |-> $past(unlocked_q))
		else $error("lock changed without unlock");
	remap_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		remap_lock_q && remap_write_req |=> !remap_write_grant)
		else $error("write granted while locked");
	wake_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pstate_q != DCW_WAKE ##1 pstate_q == DCW_WAKE |-> !cpu_run_enable [*2])
		else $error("execution resumed before start-up delay");
	wake_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cpu_run_enable) |-> $past(startup_cnt_q, 2) == 16'(STARTUP_CYCLES - 1))
		else $error("execution resumed before the start-up count ran out");
	uid_hide_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!code_prot_off |-> w3_view[15:0] == 16'h0000)
		else $error("user identifier visible under code protection");

endmodule // dcw_device_config

// File: verilog/dcw_pkg.sv
package dcw_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] DCW_OFF_CFG0     = 8'h00;
	localparam logic [7:0] DCW_OFF_CFG2     = 8'h04;
	localparam logic [7:0] DCW_OFF_CFG3     = 8'h08;
	localparam logic [7:0] DCW_OFF_CONTROL  = 8'h0c;
	localparam logic [7:0] DCW_OFF_IDENT    = 8'h10;
	localparam logic [7:0] DCW_OFF_UNLOCK   = 8'h14;
	localparam logic [7:0] DCW_OFF_RESETCTL = 8'h18;
	localparam logic [7:0] DCW_OFF_POWER    = 8'h1c;

	// ----------------------------------------------------------------
	// Configuration word two field positions
	// ----------------------------------------------------------------
	localparam int DCW_W2_DS_SELECT   = 31;
	localparam int DCW_W2_DSWD_EN     = 30;
	localparam int DCW_W2_DSWD_CLK    = 29;
	localparam int DCW_W2_DSWD_PS_LO  = 24;
	localparam int DCW_W2_DS_BROWN_EN = 23;
	localparam int DCW_W2_BROWN_EN    = 20;
	localparam int DCW_W2_ODIV_LO     = 16;
	localparam int DCW_W2_UPLL_DIS    = 15;
	localparam int DCW_W2_UIDIV_LO    = 8;
	localparam int DCW_W2_PLL_ICLK    = 7;
	localparam int DCW_W2_MUL_LO      = 4;
	localparam int DCW_W2_IDIV_LO     = 0;
	localparam logic [31:0] DCW_W2_RSVD_MASK = 32'h00687808;

	// ----------------------------------------------------------------
	// Configuration words zero and three field positions
	// ----------------------------------------------------------------
	localparam int DCW_W0_CODE_PROT   = 28;
	localparam int DCW_W0_JTAG_EN     = 2;
	localparam int DCW_W3_USBID_OWNER = 30;
	localparam int DCW_W3_REMAP_1WAY  = 29;
	localparam int DCW_W3_MDIS_1WAY   = 28;
	localparam int DCW_W3_I2C2_ALT    = 23;
	localparam int DCW_W3_I2C1_ALT    = 22;
	localparam logic [31:0] DCW_W3_RSVD_MASK = 32'h8f3f0000;

	// ----------------------------------------------------------------
	// Control register fields and values after reset
	// ----------------------------------------------------------------
	localparam int DCW_CC_REMAP_LOCK  = 13;
	localparam int DCW_CC_MDIS_LOCK   = 12;
	localparam int DCW_CC_FLASH_LP    = 8;
	localparam int DCW_CC_JTAG_EN     = 3;
	localparam int DCW_CC_TDO_EN      = 0;
	localparam logic [31:0] DCW_CC_FIXED_ONES = 32'h00000006;
	localparam logic        DCW_CC_FLASH_LP_RST = 1'b1;
	localparam logic        DCW_CC_TDO_EN_RST   = 1'b1;
	localparam int DCW_RC_BROWN_FLAG  = 1;

	// ----------------------------------------------------------------
	// Unlock keys, written in this order to the unlock register
	// ----------------------------------------------------------------
	localparam logic [31:0] DCW_KEY_ONE = 32'haa996655;
	localparam logic [31:0] DCW_KEY_TWO = 32'h556699aa;

	// ----------------------------------------------------------------
	// Regulator start-up delay
	// ----------------------------------------------------------------
	localparam int DCW_STARTUP_NS     = 10000;
	localparam int DCW_CLK_NS         = 5;
	localparam int DCW_STARTUP_CYCLES = (DCW_STARTUP_NS + DCW_CLK_NS - 1) / DCW_CLK_NS;

	localparam logic [1:0] DCW_RESP_OKAY   = 2'b00;
	localparam logic [1:0] DCW_RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		DCW_RUN   = 2'b00,
		DCW_SLEEP = 2'b01,
		DCW_DEEP  = 2'b10,
		DCW_WAKE  = 2'b11
	} dcw_power_t;

endpackage

// File: testbench/dcw_flash_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Nonvolatile configuration words as programmed
// ----------------------------------------------------------------
module dcw_flash_model (
	input  wire logic        alt,
	output logic [31:0]      nvm_word0,
	output logic [31:0]      nvm_word2,
	output logic [31:0]      nvm_word3
);
	// The alternate image turns code protection on and selects ordinary sleep.
	assign nvm_word0 = alt ? 32'hefff_fffb : 32'hffff_fffb;
	// Word two's reserved bits are left clear here so that the loader has to force them to ones.
	assign nvm_word2 = alt ? 32'h5f97_06f6 : 32'hdf97_06f6;
	assign nvm_word3 = 32'hefbf_5a3c;
endmodule // dcw_flash_model

// File: testbench/device_config_words_test.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Loader bench
// ----------------------------------------------------------------
module device_config_words_test;
	import dcw_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, alt = 1'b0, wait_instr = 1'b0, wake_event = 1'b0;
	logic brownout_detect = 1'b0, remap_write_req = 1'b0, mdis_write_req = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] nvm_word0, nvm_word2, nvm_word3, s_axi_rdata, rd;
	logic [3:0] usbpll_in_divider, syspll_in_divider;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic deep_sleep_active, sleep_active, cpu_run_enable, ds_watchdog_run;
	logic ds_watchdog_clock_select, brownout_detect_active, brownout_reset, usbpll_enable;
	logic syspll_input_select, usb_id_pin_owner, i2c_chan1_alt_pins, i2c_chan2_alt_pins;
	logic remap_write_grant, mdis_write_grant, low_power_flash_read;
	logic jtag_port_enable, two_wire_tdo_enable;
	logic [5:0] ds_watchdog_ratio_log2;
	logic [8:0] syspll_out_divisor;
	logic [4:0] syspll_multiplier;
	logic [15:0] user_identifier;
	int err_total = 0, total_checks = 0, cyc = 0;

	dcw_flash_model u_nvm (.*);
	dcw_device_config #(.STARTUP_CYCLES(4)) u_dut (.*);

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// A hung handshake would otherwise stall the run forever.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic reset_dut(input logic a);
		@(posedge aclk);
		aresetn <= 1'b0;
		alt <= a;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask

	task automatic req(input logic r, input logic m, input logic [1:0] e);
		@(posedge aclk);
		remap_write_req <= r;
		mdis_write_req <= m;
		@(posedge aclk);
		remap_write_req <= 1'b0;
		mdis_write_req <= 1'b0;
		#1;
		chk({remap_write_grant, mdis_write_grant}, e, "grant");
	endtask

	task automatic t_decode();
		chk({ds_watchdog_clock_select, ds_watchdog_ratio_log2}, 7'h24, "watchdog");
		chk(syspll_out_divisor, 9'h100, "out divisor");
		chk({usbpll_enable, usbpll_in_divider}, 5'h1a, "usb pll");
		chk({syspll_input_select, syspll_multiplier}, 6'h38, "pll mult");
		chk(syspll_in_divider, 4'ha, "in divider");
		chk({usb_id_pin_owner, i2c_chan2_alt_pins, i2c_chan1_alt_pins}, 3'h6, "pins");
		chk(brownout_detect_active, 1'b1, "brownout active");
		chk({low_power_flash_read, jtag_port_enable, two_wire_tdo_enable}, 3'h5, "ctl");
		chk(user_identifier, 16'h5a3c, "user id");
		rdr(DCW_OFF_CFG2);
		chk(rd, 32'hdfff_7efe, "word2");
		rdr(DCW_OFF_IDENT);
		chk(rd, 32'h1000_0123, "ident");
		rdr(8'h20);
		chk(rd, 32'h0, "unmapped data");
		chk(rr, DCW_RESP_SLVERR, "unmapped resp");
	endtask

	task automatic t_locks();
		req(1'b1, 1'b0, 2'h2);
		req(1'b1, 1'b0, 2'h0);
		req(1'b0, 1'b1, 2'h1);
		req(1'b0, 1'b1, 2'h1);
		wr(DCW_OFF_CONTROL, 32'h0000_3107);
		rdr(DCW_OFF_CONTROL);
		chk(rd, 32'h0000_0107, "lock without key");
		wr(DCW_OFF_UNLOCK, DCW_KEY_ONE);
		wr(DCW_OFF_UNLOCK, DCW_KEY_TWO);
		wr(DCW_OFF_CONTROL, 32'h0000_3107);
		chk(rr, DCW_RESP_OKAY, "bresp");
		rdr(DCW_OFF_CONTROL);
		chk(rd, 32'h0000_3107, "lock after key");
		req(1'b0, 1'b1, 2'h0);
		req(1'b1, 1'b1, 2'h0);
	endtask

	task automatic t_power(input logic d);
		int n;
		@(posedge aclk);
		wait_instr <= 1'b1;
		@(posedge aclk);
		wait_instr <= 1'b0;
		rdr(DCW_OFF_POWER);
		chk(rd, d ? 32'h2 : 32'h1, "state");
		chk({deep_sleep_active, sleep_active, ds_watchdog_run, cpu_run_enable}, {d, !d, d, 1'b0}, "sleep");
		chk(brownout_detect_active, 1'b1, "detect in sleep");
		@(posedge aclk);
		wake_event <= 1'b1;
		@(posedge aclk);
		wake_event <= 1'b0;
		n = 0;
		while (cpu_run_enable !== 1'b1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		chk(n > 3 && n < 9, 1'b1, "startup delay");
	endtask

	task automatic t_brownout();
		int n;
		@(posedge aclk);
		brownout_detect <= 1'b1;
		@(posedge aclk);
		brownout_detect <= 1'b0;
		n = 0;
		while (brownout_reset !== 1'b1 && n < 8) begin
			@(posedge aclk);
			n++;
		end
		chk(brownout_reset, 1'b1, "brownout pulse");
		rdr(DCW_OFF_RESETCTL);
		chk(rd[1], 1'b1, "brownout flag");
		wr(DCW_OFF_RESETCTL, 32'h0);
		rdr(DCW_OFF_RESETCTL);
		chk(rd[1], 1'b0, "brownout clear");
	endtask

	initial begin
		reset_dut(1'b0);
		t_decode();
		t_locks();
		t_power(1'b1);
		t_brownout();
		reset_dut(1'b1);
		rdr(DCW_OFF_CFG3);
		chk(rd, 32'hefbf_0000, "hidden id");
		t_power(1'b0);
		end_of_test();
	end
endmodule // device_config_words_test
